// >>> design/tsa_cfg.svh
// Register offsets, field positions and reset values of the slope converter timer
`ifndef TSA_CFG_SVH
`define TSA_CFG_SVH
`define TSA_OFS_TCR     4'h0
`define TSA_OFS_TSR     4'h1
`define TSA_OFS_CNT_HI  4'h2
`define TSA_OFS_CNT_LO  4'h3
`define TSA_OFS_CMP_HI  4'h4
`define TSA_OFS_CMP_LO  4'h5
`define TSA_OFS_CAP_HI  4'h6
`define TSA_OFS_CAP_LO  4'h7
`define TSA_OFS_ACR     4'h8
`define TSA_OFS_ASR     4'h9
`define TSA_TCR_EDGE    1
`define TSA_TCR_OVIE    5
`define TSA_TCR_CMIE    6
`define TSA_TCR_CPIE    7
`define TSA_TSR_OVF     5
`define TSA_TSR_CMF     6
`define TSA_TSR_CPF     7
`define TSA_ACR_SRC     0
`define TSA_ACR_MLO     1
`define TSA_ACR_MHI     2
`define TSA_ACR_CHG     3
`define TSA_ASR_FLAGB   0
`define TSA_ASR_CMPB    1
`define TSA_ASR_FLGRST  2
`define TSA_CNT_RESET   16'hFFFC
`define TSA_CMP_INIT    16'hFFFF
`endif

// >>> design/tsa_pkg.sv
// Types shared by the slope converter timer
package tsa_pkg;
  typedef enum logic [1:0] {
    TSA_MODE_MAN0,
    TSA_MODE_MAN1,
    TSA_MODE_AUTO_OVF,
    TSA_MODE_AUTO_CMP
  } tsa_mode_t;
endpackage : tsa_pkg

// >>> design/tsa_top.sv
// Timer driven single slope converter control with flag sequences and ramp charge logic
`include "tsa_cfg.svh"

// What this block does
// - Overflow flag sets whenever the counter wraps to zero, enable or not.
// - Overflow flag clears only on status read, then counter low byte read.
// - Reset loads the counter just below wrap so overflow comes soon.
// - Compare flag sets when counter equals compare value, enable or not.
// - Compare flag clears only on status read, then compare low byte read.
// - A set compare flag blocks further compare matches.
// - Reset leaves the compare value register unchanged.
// - Capture flag sets and counter is latched on each qualifying capture.
// - Capture flag clears only on status read, then capture low byte read.
// - While capture flag is set, new captures are ignored, time kept.
// - Capture flag overrides start flags; clearing it with start pending charges.
// - Capture edge is rising or falling per the edge select bit.
// - Capture source is the pin or comparator b per source select bit.
// - Overflow-driven mode starts charge on overflow flag, even if pending.
// - Compare-driven mode starts charge on compare flag, even if pending.
// - Hardware sets charge control and comparator b flags itself.
// - Writing one to the flag reset bit clears the comparator b flag unless comparator b is high.
// - A software write of charge control takes effect at once.
// - Software clearing charge control ends the ramp at once.
module tsa_top
  import tsa_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  input  wire logic        capture_pin_in,
  input  wire logic        comparator_b_in,
  output logic             ramp_pin_out,
  output logic             irq_request_out
);

  // ==========================================================
  // Input synchronisers
  logic [1:0] pin_sync_r;
  logic [1:0] cmp_sync_r;
  logic       trig_prev_r;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pin_sync_r <= 2'h0;
      cmp_sync_r <= 2'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[0], capture_pin_in};
      cmp_sync_r <= {cmp_sync_r[0], comparator_b_in};
    end
  end

  // ==========================================================
  // Registers and state
  logic [15:0] counter_r;
  logic [15:0] compare_r = `TSA_CMP_INIT;
  logic [15:0] captured_r;
  logic        overflow_flag_r;
  logic        compare_flag_r;
  logic        capture_flag_r;
  logic        overflow_irq_enable_r;
  logic        compare_irq_enable_r;
  logic        capture_irq_enable_r;
  logic        capture_edge_select_r;
  logic        capture_source_select_r;
  tsa_mode_t   mode_r;
  logic        charge_control_r;
  logic        comparator_b_latched_flag_r;
  logic        ovf_armed_r;
  logic        cmp_armed_r;
  logic        cap_armed_r;
  logic [7:0]  rdata_r;

  wire wr_tcr  = wr_in && (addr_in == `TSA_OFS_TCR);
  wire wr_cmph = wr_in && (addr_in == `TSA_OFS_CMP_HI);
  wire wr_cmpl = wr_in && (addr_in == `TSA_OFS_CMP_LO);
  wire wr_acr  = wr_in && (addr_in == `TSA_OFS_ACR);
  wire wr_asr  = wr_in && (addr_in == `TSA_OFS_ASR);
  wire rd_tsr  = rd_in && (addr_in == `TSA_OFS_TSR);
  wire rd_cntl = rd_in && (addr_in == `TSA_OFS_CNT_LO);
  wire rd_cmpl = rd_in && (addr_in == `TSA_OFS_CMP_LO);
  wire rd_capl = rd_in && (addr_in == `TSA_OFS_CAP_LO);

  // ==========================================================
  // Counter and event detection
  wire        wrap_ev   = (counter_r == 16'hFFFF);
  wire        match_ev  = (counter_r == compare_r) && !compare_flag_r;
  wire        trig_src  = capture_source_select_r ? cmp_sync_r[1] : pin_sync_r[1];
  wire        edge_ev   = capture_edge_select_r ? (trig_src && !trig_prev_r)
                                                : (!trig_src && trig_prev_r);
  wire        capture_ev = edge_ev && !capture_flag_r;
  wire        auto_mode = (mode_r == TSA_MODE_AUTO_OVF) || (mode_r == TSA_MODE_AUTO_CMP);

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      counter_r <= `TSA_CNT_RESET;
    end else begin
      counter_r <= counter_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      trig_prev_r <= 1'b0;
    end else begin
      trig_prev_r <= trig_src;
    end
  end

  // Compare value has no reset term; only its power-up value is given
  always_ff @(posedge clk_sys_in) begin
    if (wr_cmph) begin
      compare_r[15:8] <= wdata_in;
    end
    if (wr_cmpl) begin
      compare_r[7:0] <= wdata_in;
    end
  end

  // ==========================================================
  // Flags: set wins over clear; clear needs status read then low byte read
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      overflow_flag_r <= 1'b0;
      ovf_armed_r     <= 1'b0;
    end else begin
      if (wrap_ev) begin
        overflow_flag_r <= 1'b1;
      end else if (rd_cntl && ovf_armed_r) begin
        overflow_flag_r <= 1'b0;
      end
      if (rd_tsr) begin
        ovf_armed_r <= overflow_flag_r;
      end else if (rd_cntl) begin
        ovf_armed_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      compare_flag_r <= 1'b0;
      cmp_armed_r    <= 1'b0;
    end else begin
      if (match_ev) begin
        compare_flag_r <= 1'b1;
      end else if (rd_cmpl && cmp_armed_r) begin
        compare_flag_r <= 1'b0;
      end
      if (rd_tsr) begin
        cmp_armed_r <= compare_flag_r;
      end else if (rd_cmpl) begin
        cmp_armed_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      capture_flag_r <= 1'b0;
      cap_armed_r    <= 1'b0;
      captured_r     <= 16'h0000;
    end else begin
      if (capture_ev) begin
        capture_flag_r <= 1'b1;
        captured_r     <= counter_r;
      end else if (rd_capl && cap_armed_r) begin
        capture_flag_r <= 1'b0;
      end
      if (rd_tsr) begin
        cap_armed_r <= capture_flag_r;
      end else if (rd_capl) begin
        cap_armed_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Control registers
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      overflow_irq_enable_r   <= 1'b0;
      compare_irq_enable_r    <= 1'b0;
      capture_irq_enable_r    <= 1'b0;
      capture_edge_select_r   <= 1'b0;
    end else if (wr_tcr) begin
      overflow_irq_enable_r   <= wdata_in[`TSA_TCR_OVIE];
      compare_irq_enable_r    <= wdata_in[`TSA_TCR_CMIE];
      capture_irq_enable_r    <= wdata_in[`TSA_TCR_CPIE];
      capture_edge_select_r   <= wdata_in[`TSA_TCR_EDGE];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      capture_source_select_r <= 1'b0;
      mode_r                  <= TSA_MODE_MAN0;
    end else if (wr_acr) begin
      capture_source_select_r <= wdata_in[`TSA_ACR_SRC];
      mode_r <= tsa_mode_t'({wdata_in[`TSA_ACR_MHI], wdata_in[`TSA_ACR_MLO]});
    end
  end

  // ==========================================================
  // Charge control: start flag raises it, capture flag holds it off in the auto modes
  wire start_flag = (mode_r == TSA_MODE_AUTO_OVF) ? overflow_flag_r :
                    (mode_r == TSA_MODE_AUTO_CMP) ? compare_flag_r : 1'b0;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      charge_control_r <= 1'b0;
    end else if (wr_acr && !wdata_in[`TSA_ACR_CHG]) begin
      charge_control_r <= 1'b0;
    end else if (wr_acr && wdata_in[`TSA_ACR_CHG]) begin
      charge_control_r <= 1'b1;
    end else if (auto_mode && (capture_flag_r || capture_ev)) begin
      charge_control_r <= 1'b0;
    end else if (start_flag && !capture_flag_r) begin
      charge_control_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      comparator_b_latched_flag_r <= 1'b0;
    end else if (cmp_sync_r[1]) begin
      comparator_b_latched_flag_r <= 1'b1;
    end else if (wr_asr && wdata_in[`TSA_ASR_FLGRST]) begin
      comparator_b_latched_flag_r <= 1'b0;
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rdata_r <= 8'h00;
    end else if (rd_in) begin
      unique case (addr_in)
        `TSA_OFS_TCR:    rdata_r <= {capture_irq_enable_r, compare_irq_enable_r,
                                     overflow_irq_enable_r, 3'h0,
                                     capture_edge_select_r, 1'b0};
        `TSA_OFS_TSR:    rdata_r <= {capture_flag_r, compare_flag_r, overflow_flag_r, 5'h00};
        `TSA_OFS_CNT_HI: rdata_r <= counter_r[15:8];
        `TSA_OFS_CNT_LO: rdata_r <= counter_r[7:0];
        `TSA_OFS_CMP_HI: rdata_r <= compare_r[15:8];
        `TSA_OFS_CMP_LO: rdata_r <= compare_r[7:0];
        `TSA_OFS_CAP_HI: rdata_r <= captured_r[15:8];
        `TSA_OFS_CAP_LO: rdata_r <= captured_r[7:0];
        `TSA_OFS_ACR:    rdata_r <= {4'h0, charge_control_r, mode_r, capture_source_select_r};
        `TSA_OFS_ASR:    rdata_r <= {6'h00, cmp_sync_r[1], comparator_b_latched_flag_r};
        default:         rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign rdata_out       = rdata_r;
  assign ramp_pin_out    = charge_control_r;
  assign irq_request_out = (overflow_flag_r && overflow_irq_enable_r) ||
                           (compare_flag_r && compare_irq_enable_r) ||
                           (capture_flag_r && capture_irq_enable_r);

  // ==========================================================
  // Assertions
  sequence s_status_read(flag);
    rd_tsr && flag;
  endsequence

  property p_ovf_set;
    @(posedge clk_sys_in) disable iff (rst_in) wrap_ev |=> overflow_flag_r;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set on wrap");

  property p_ovf_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
      $fell(overflow_flag_r) |-> $past(rd_cntl) && $past(ovf_armed_r);
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag cleared wrongly");

  property p_ovf_clear;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_status_read(overflow_flag_r) ##1 !rd_cntl ##1 (rd_cntl && !wrap_ev) |=> !overflow_flag_r;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared");

  property p_reset_cnt;
    @(posedge clk_sys_in) $fell(rst_in) |-> counter_r == `TSA_CNT_RESET;
  endproperty
  a_reset_cnt: assert property (p_reset_cnt) else $error("counter reset value wrong");

  property p_cmp_set;
    @(posedge clk_sys_in) disable iff (rst_in)
      match_ev |=> compare_flag_r;
  endproperty
  a_cmp_set: assert property (p_cmp_set) else $error("compare flag missed");

  property p_cap_lock;
    @(posedge clk_sys_in) disable iff (rst_in)
      capture_flag_r && !(rd_capl && cap_armed_r) |=> $stable(captured_r) && capture_flag_r;
  endproperty
  a_cap_lock: assert property (p_cap_lock) else $error("capture changed while flagged");

  property p_cap_set;
    @(posedge clk_sys_in) disable iff (rst_in)
      capture_ev |=> capture_flag_r && captured_r == $past(counter_r);
  endproperty
  a_cap_set: assert property (p_cap_set) else $error("capture not latched");

  property p_auto_stop;
    @(posedge clk_sys_in) disable iff (rst_in)
      auto_mode && capture_flag_r && !wr_acr |=> !charge_control_r;
  endproperty
  a_auto_stop: assert property (p_auto_stop) else $error("charge on during capture");

  property p_start;
    @(posedge clk_sys_in) disable iff (rst_in)
      start_flag && !capture_flag_r && !capture_ev && !wr_acr |=> charge_control_r;
  endproperty
  a_start: assert property (p_start) else $error("ramp did not start");

  property p_flag_rst;
    @(posedge clk_sys_in) disable iff (rst_in)
      wr_asr && wdata_in[`TSA_ASR_FLGRST] && !cmp_sync_r[1] |=> !comparator_b_latched_flag_r;
  endproperty
  a_flag_rst: assert property (p_flag_rst) else $error("comparator flag not reset");

  property p_cmp_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
      $fell(compare_flag_r) |-> $past(rd_cmpl) && $past(cmp_armed_r);
  endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("compare flag cleared wrongly");

  property p_cmp_clear;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_status_read(compare_flag_r) ##1 !rd_cmpl ##1 rd_cmpl |=> !compare_flag_r;
  endproperty
  a_cmp_clear: assert property (p_cmp_clear) else $error("compare flag not cleared");

  property p_cap_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
      $fell(capture_flag_r) |-> $past(rd_capl) && $past(cap_armed_r);
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture flag cleared wrongly");

  property p_cap_clear;
    @(posedge clk_sys_in) disable iff (rst_in)
      s_status_read(capture_flag_r) ##1 !rd_capl ##1 rd_capl |=> !capture_flag_r;
  endproperty
  a_cap_clear: assert property (p_cap_clear) else $error("capture flag not cleared");

  property p_resume;
    @(posedge clk_sys_in) disable iff (rst_in)
      $fell(capture_flag_r) && start_flag && !capture_ev && !wr_acr |=> charge_control_r;
  endproperty
  a_resume: assert property (p_resume) else $error("charge did not resume");

  property p_charge_wr;
    @(posedge clk_sys_in) disable iff (rst_in)
      wr_acr |=> charge_control_r == $past(wdata_in[`TSA_ACR_CHG]);
  endproperty
  a_charge_wr: assert property (p_charge_wr) else $error("charge write ignored");

  property p_edge_pin;
    @(posedge clk_sys_in) disable iff (rst_in)
      !capture_source_select_r && !capture_edge_select_r && $stable(capture_source_select_r) &&
      $fell(pin_sync_r[1]) && !capture_flag_r |=> capture_flag_r;
  endproperty
  a_edge_pin: assert property (p_edge_pin) else $error("pin falling edge missed");

  property p_edge_cmp;
    @(posedge clk_sys_in) disable iff (rst_in)
      capture_source_select_r && capture_edge_select_r && $stable(capture_source_select_r) &&
      $rose(cmp_sync_r[1]) && !capture_flag_r |=> capture_flag_r;
  endproperty
  a_edge_cmp: assert property (p_edge_cmp) else $error("comparator rising edge missed");

  property p_cmpb_latch;
    @(posedge clk_sys_in) disable iff (rst_in)
      cmp_sync_r[1] |=> comparator_b_latched_flag_r;
  endproperty
  a_cmpb_latch: assert property (p_cmpb_latch) else $error("comparator flag not latched");

endmodule : tsa_top

// >>> dv/tsa_ramp_model.sv
// Ramp capacitor on the charge pin with comparator b watching its level
module tsa_ramp_model #(
  parameter int THRESH = 40
) (
  input  wire logic clk_sys_in,
  input  wire logic ramp_pin_in,
  output logic      comparator_b_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int level_r = 0;
  // ==========
  // Charge
  // Rises one step a cycle while charged, dumped at once when released
  always_ff @(posedge clk_sys_in) begin
    level_r <= ramp_pin_in ? level_r + 1 : 0;
  end
  assign comparator_b_out = (level_r >= THRESH);
endmodule : tsa_ramp_model

// >>> dv/tb_tsa_top.sv
// Self-checking bench for the slope converter timer control
`include "tsa_cfg.svh"
module tb_tsa_top
  import tsa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys_in;
  logic       rst_in;
  logic [3:0] addr_in;
  logic [7:0] wdata_in;
  logic       wr_in;
  logic       rd_in;
  logic [7:0] rdata_out;
  logic       capture_pin_in;
  logic       comparator_b_in;
  logic       ramp_pin_out;
  logic       irq_request_out;
  int         fails = 0;
  int         check_count = 0;

  tsa_top dut_u (
    .clk_sys_in      (clk_sys_in),
    .rst_in          (rst_in),
    .addr_in         (addr_in),
    .wdata_in        (wdata_in),
    .wr_in           (wr_in),
    .rd_in           (rd_in),
    .rdata_out       (rdata_out),
    .capture_pin_in  (capture_pin_in),
    .comparator_b_in (comparator_b_in),
    .ramp_pin_out    (ramp_pin_out),
    .irq_request_out (irq_request_out)
  );
  tsa_ramp_model model_u (
    .clk_sys_in       (clk_sys_in),
    .ramp_pin_in      (ramp_pin_out),
    .comparator_b_out (comparator_b_in)
  );

  // ==========
  // Bus tasks and checks
  function automatic logic [7:0] acr_val(input logic c, input tsa_mode_t m, input logic s);
    acr_val = 8'h00;
    acr_val[`TSA_ACR_CHG] = c;
    acr_val[`TSA_ACR_MHI:`TSA_ACR_MLO] = m;
    acr_val[`TSA_ACR_SRC] = s;
  endfunction : acr_val
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask : rd
  task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(v & m, e);
  endtask : rchk
  task automatic wait_ramp(input logic e, input int bound);
    for (int i = 0; i < bound; i++) begin
      #1;
      if (ramp_pin_out === e) break;
      @(posedge clk_sys_in);
    end
    chk({7'h0, ramp_pin_out}, {7'h0, e});
    if (ramp_pin_out !== e) finish_test();
  endtask : wait_ramp

  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end

  // ==========
  // Main sequence
  initial begin
    logic [7:0]  v;
    logic [7:0]  v2;
    logic [7:0]  c0;
    logic [15:0] t;
    rst_in         = 1'b1;
    addr_in        = 4'h0;
    wdata_in       = 8'h00;
    wr_in          = 1'b0;
    rd_in          = 1'b0;
    capture_pin_in = 1'b0;
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    // Low byte reads with no status read before them must not clear
    rd(`TSA_OFS_CAP_LO, v);
    rd(`TSA_OFS_CNT_LO, v);
    rd(`TSA_OFS_CMP_LO, v);
    rchk(`TSA_OFS_TSR, 8'hE0, 8'h60);
    rchk(`TSA_OFS_TSR, 8'hE0, 8'h60);
    $display("Test reset done");
    // Overflow driven mode with a pending start flag
    wr(`TSA_OFS_TCR, 8'h22);
    wr(`TSA_OFS_ACR, acr_val(1'b0, TSA_MODE_AUTO_OVF, 1'b1));
    wait_ramp(1'b1, 3);
    chk({7'h0, irq_request_out}, 8'h01);
    wait_ramp(1'b0, 80);
    rchk(`TSA_OFS_TSR, 8'hE0, 8'hE0);
    chk({7'h0, ramp_pin_out}, 8'h00);
    rd(`TSA_OFS_CAP_LO, v);
    wait_ramp(1'b1, 3);
    wr(`TSA_OFS_ACR, acr_val(1'b0, TSA_MODE_MAN0, 1'b1));
    wait_ramp(1'b0, 2);
    rd(`TSA_OFS_TSR, v);
    rd(`TSA_OFS_CNT_LO, v);
    rd(`TSA_OFS_TSR, v);
    rd(`TSA_OFS_CMP_LO, v);
    rd(`TSA_OFS_TSR, v);
    rd(`TSA_OFS_CAP_LO, v);
    rchk(`TSA_OFS_TSR, 8'hE0, 8'h00);
    chk({7'h0, irq_request_out}, 8'h00);
    $display("Test overflow mode done");
    // Compare driven mode
    rd(`TSA_OFS_CNT_HI, v);
    rd(`TSA_OFS_CNT_LO, v2);
    t = {v, v2} + 16'h0080;
    wr(`TSA_OFS_CMP_HI, t[15:8]);
    wr(`TSA_OFS_CMP_LO, t[7:0]);
    wr(`TSA_OFS_ACR, acr_val(1'b0, TSA_MODE_AUTO_CMP, 1'b1));
    chk({7'h0, ramp_pin_out}, 8'h00);
    wait_ramp(1'b1, 400);
    wait_ramp(1'b0, 80);
    rchk(`TSA_OFS_TSR, 8'hE0, 8'hC0);
    wr(`TSA_OFS_ACR, acr_val(1'b0, TSA_MODE_MAN0, 1'b1));
    rd(`TSA_OFS_CMP_LO, v);
    rd(`TSA_OFS_TSR, v);
    rd(`TSA_OFS_CAP_LO, v);
    rchk(`TSA_OFS_TSR, 8'hE0, 8'h00);
    $display("Test compare mode done");
    // Pin captures, lockout and edge select
    wr(`TSA_OFS_ACR, acr_val(1'b0, TSA_MODE_MAN0, 1'b0));
    rd(`TSA_OFS_CNT_LO, c0);
    @(posedge clk_sys_in);
    capture_pin_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    rd(`TSA_OFS_CAP_LO, v);
    v2 = v - c0;
    chk({7'h0, (v2 >= 8'h01 && v2 <= 8'h0C)}, 8'h01);
    @(posedge clk_sys_in);
    capture_pin_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    capture_pin_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    rchk(`TSA_OFS_CAP_LO, 8'hFF, v);
    rchk(`TSA_OFS_TSR, 8'h80, 8'h80);
    rd(`TSA_OFS_CAP_LO, v);
    rchk(`TSA_OFS_TSR, 8'h80, 8'h00);
    wr(`TSA_OFS_TCR, 8'h00);
    capture_pin_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    rchk(`TSA_OFS_TSR, 8'h80, 8'h80);
    rd(`TSA_OFS_CAP_LO, v);
    $display("Test pin capture done");
    // Manual charge and comparator b flags
    wr(`TSA_OFS_ACR, acr_val(1'b1, TSA_MODE_MAN1, 1'b0));
    wait_ramp(1'b1, 2);
    repeat (50) @(posedge clk_sys_in);
    rchk(`TSA_OFS_ASR, 8'h03, 8'h03);
    wr(`TSA_OFS_ACR, acr_val(1'b0, TSA_MODE_MAN1, 1'b0));
    wait_ramp(1'b0, 2);
    repeat (4) @(posedge clk_sys_in);
    rchk(`TSA_OFS_ASR, 8'h03, 8'h01);
    wr(`TSA_OFS_ASR, 8'h04);
    rchk(`TSA_OFS_ASR, 8'h03, 8'h00);
    wr(4'hF, 8'hFF);
    rchk(4'hF, 8'hFF, 8'h00);
    $display("Test comparator flags done");
    finish_test();
  end
endmodule : tb_tsa_top
